//--- src/pcw_config_regs.sv
/*
 * Control words A and B of the clock conditioner: decode of latched words
 * into divider ratios, lock pin mode, charge pump and output controls.
 * Assumes lock indications and divider outputs come from analogue-side logic
 * on sys_clk_in; serial pins come from the host on their own clock.
 */
`timescale 1ns/1ps
`include "pcw_consts.svh"

module pcw_config_regs (
    input  wire logic          sys_clk_in,
    input  wire logic          sys_rst_in,
    input  wire logic          ser_clk_in,
    input  wire logic          ser_data_in,
    input  wire logic          latch_en_in,
    input  wire logic          dig_lock_in,
    input  wire logic          ana_lock_in,
    input  wire logic          fb_div_pulse_in,
    input  wire logic          ref_div_pulse_in,
    input  wire logic          ld_prescale_in,
    output logic [11:0]        ref_ratio_out,
    output logic [17:0]        fb_ratio_out,
    output logic               ref_ratio_bad_out,
    output logic               fb_ratio_bad_out,
    output logic               full_shutdown_bit_out,
    output logic               clocks_off_out,
    output logic               pump_float_bit_out,
    output logic               pump_polarity_bit_out,
    output logic [5:0]         pump_gain_scale_out,
    output logic               lock_detect_prescale_out,
    output logic               lock_status_pin_out,
    output logic               lock_status_pin_oe_out,
    output logic               ld_sel_bad_out
);

    ////////////////////////////////////////////////////////////////////////
    // serial receive
    logic [`PCW_WORD_BITS-1:0] rx_word;
    logic                      rx_strobe;

    pcw_shift_rx u_rx (
        .link_clk_in     (ser_clk_in),
        .sys_clk_in      (sys_clk_in),
        .sys_rst_in      (sys_rst_in),
        .ser_data_in     (ser_data_in),
        .latch_en_in     (latch_en_in),
        .word_out        (rx_word),
        .word_strobe_out (rx_strobe)
    );

    function automatic logic [5:0] gain_scale(input logic [1:0] code);
        case (code)
            2'h0:    gain_scale = `PCW_GAIN_X1;
            2'h1:    gain_scale = `PCW_GAIN_X4;
            2'h2:    gain_scale = `PCW_GAIN_X16;
            default: gain_scale = `PCW_GAIN_X32;
        endcase
    endfunction : gain_scale

    ////////////////////////////////////////////////////////////////////////
    // latched fields; only a full latched word with matching address updates
    logic [11:0] ref_ratio;
    logic [17:0] fb_ratio;
    logic [3:0]  ld_sel;
    logic        shut;
    logic        goe;
    logic        cp_float;
    logic        cp_pol;
    logic [1:0]  cp_gain;
    logic [11:0] next_ref_ratio;
    logic [17:0] next_fb_ratio;
    logic [3:0]  next_ld_sel;
    logic        next_shut;
    logic        next_goe;
    logic        next_cp_float;
    logic        next_cp_pol;
    logic [1:0]  next_cp_gain;
    logic [3:0]  rx_addr;

    always_comb begin
        rx_addr        = rx_word[`PCW_ADDR_MSB:`PCW_ADDR_LSB];
        next_ref_ratio = ref_ratio;
        next_fb_ratio  = fb_ratio;
        next_ld_sel    = ld_sel;
        next_shut      = shut;
        next_goe       = goe;
        next_cp_float  = cp_float;
        next_cp_pol    = cp_pol;
        next_cp_gain   = cp_gain;
        if (rx_strobe && rx_addr == `PCW_ADDR_A) begin
            next_ref_ratio = rx_word[`PCW_A_REF_MSB:`PCW_A_REF_LSB];
            next_ld_sel    = rx_word[`PCW_A_LDSEL_MSB:`PCW_A_LDSEL_LSB];
            next_cp_pol    = rx_word[`PCW_A_POL_BIT];
            next_cp_float  = rx_word[`PCW_A_FLOAT_BIT];
            next_shut      = rx_word[`PCW_A_SHUT_BIT];
            next_goe       = rx_word[`PCW_A_GOE_BIT];
        end
        if (rx_strobe && rx_addr == `PCW_ADDR_B) begin
            next_fb_ratio = rx_word[`PCW_B_FB_MSB:`PCW_B_FB_LSB];
            next_cp_gain  = rx_word[`PCW_B_GAIN_MSB:`PCW_B_GAIN_LSB];
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ref_ratio <= `PCW_REF_RST;
            fb_ratio  <= `PCW_FB_RST;
            ld_sel    <= `PCW_LDSEL_RST;
            shut      <= `PCW_SHUT_RST;
            goe       <= `PCW_GOE_RST;
            cp_float  <= `PCW_FLOAT_RST;
            cp_pol    <= `PCW_POL_RST;
            cp_gain   <= `PCW_GAIN_RST;
        end else begin
            ref_ratio <= next_ref_ratio;
            fb_ratio  <= next_fb_ratio;
            ld_sel    <= next_ld_sel;
            shut      <= next_shut;
            goe       <= next_goe;
            cp_float  <= next_cp_float;
            cp_pol    <= next_cp_pol;
            cp_gain   <= next_cp_gain;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin inputs from the analogue side pass two flops
    logic [4:0] in_s1;
    logic [4:0] in_s2;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            in_s1 <= '0;
            in_s2 <= '0;
        end else begin
            in_s1 <= {ld_prescale_in, ref_div_pulse_in, fb_div_pulse_in, ana_lock_in, dig_lock_in};
            in_s2 <= in_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // divider output toggles give 50% duty copies
    logic fb_tog;
    logic ref_tog;
    logic fb_prev;
    logic ref_prev;
    logic next_fb_tog;
    logic next_ref_tog;

    always_comb begin
        next_fb_tog  = fb_tog ^ (in_s2[2] & ~fb_prev);
        next_ref_tog = ref_tog ^ (in_s2[3] & ~ref_prev);
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fb_tog   <= 1'b0;
            ref_tog  <= 1'b0;
            fb_prev  <= 1'b0;
            ref_prev <= 1'b0;
        end else begin
            fb_tog   <= next_fb_tog;
            ref_tog  <= next_ref_tog;
            fb_prev  <= in_s2[2];
            ref_prev <= in_s2[3];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock pin mux; shutdown releases the pin whatever the mode
    logic pin;
    logic pin_oe;
    logic sel_bad;
    logic next_pin;
    logic next_pin_oe;
    logic next_sel_bad;

    always_comb begin
        next_pin     = 1'b0;
        next_pin_oe  = 1'b1;
        next_sel_bad = 1'b0;
        case (pcw_pkg::pcw_ld_sel_t'(ld_sel))
            pcw_pkg::PCW_LD_HIZ:      next_pin_oe = 1'b0;
            pcw_pkg::PCW_LD_HIGH:     next_pin = 1'b1;
            pcw_pkg::PCW_LD_LOW:      next_pin = 1'b0;
            pcw_pkg::PCW_LD_DLD_HI:   next_pin = in_s2[0];
            pcw_pkg::PCW_LD_DLD_LO:   next_pin = ~in_s2[0];
            pcw_pkg::PCW_LD_ALD_PP:   next_pin = in_s2[1];
            pcw_pkg::PCW_LD_ALD_NMOS: begin
                next_pin    = 1'b0;
                next_pin_oe = ~in_s2[1];
            end
            pcw_pkg::PCW_LD_ALD_PMOS: begin
                next_pin    = 1'b1;
                next_pin_oe = in_s2[1];
            end
            pcw_pkg::PCW_LD_FB_HALF:  next_pin = fb_tog;
            pcw_pkg::PCW_LD_REF_OUT:  next_pin = ref_tog;
            default: begin
                next_pin_oe  = 1'b0;
                next_sel_bad = 1'b1;
            end
        endcase
        if (shut) begin
            next_pin    = 1'b0;
            next_pin_oe = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin     <= 1'b0;
            pin_oe  <= 1'b0;
            sel_bad <= 1'b0;
        end else begin
            pin     <= next_pin;
            pin_oe  <= next_pin_oe;
            sel_bad <= next_sel_bad;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    logic [5:0] gain_q;
    logic       off_q;
    logic       float_q;
    logic       ref_bad_q;
    logic       fb_bad_q;
    logic       pre_q;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            gain_q    <= `PCW_GAIN_X1;
            off_q     <= 1'b0;
            float_q   <= 1'b0;
            ref_bad_q <= 1'b0;
            fb_bad_q  <= 1'b0;
            pre_q     <= 1'b0;
        end else begin
            gain_q    <= gain_scale(next_cp_gain);
            off_q     <= ~next_goe | next_shut;
            float_q   <= next_cp_float | next_shut;
            ref_bad_q <= (next_ref_ratio == 12'h000);
            fb_bad_q  <= (next_fb_ratio == 18'h00000);
            pre_q     <= in_s2[4];
        end
    end

    // ratios leave separately; total feedback is prescaler times fb ratio downstream
    assign ref_ratio_out            = ref_ratio;
    assign fb_ratio_out             = fb_ratio;
    assign ref_ratio_bad_out        = ref_bad_q;
    assign fb_ratio_bad_out         = fb_bad_q;
    assign full_shutdown_bit_out    = shut;
    assign clocks_off_out           = off_q;
    assign pump_float_bit_out       = float_q;
    assign pump_polarity_bit_out    = cp_pol;
    assign pump_gain_scale_out      = gain_q;
    assign lock_detect_prescale_out = pre_q;
    assign lock_status_pin_out      = pin;
    assign lock_status_pin_oe_out   = pin_oe;
    assign ld_sel_bad_out           = sel_bad;

endmodule : pcw_config_regs

//--- src/pcw_consts.svh
/*
 * Constants for the clock-conditioner configuration word block: word layout,
 * address codes, field positions and power-on values.
 * Assumes it is included by bare name from the package and the design modules.
 */
// Operation
// - reference ratio is 12-bit binary, 1 to 4095, zero invalid, defaults 10.
// - lock pin select 0 high-z default, 1 drives high, 2 drives low.
// - codes 3,4 digital lock high/low; 5,6,7 analog push-pull, nmos, pmos drain.
// - code 9 feedback divider half, 11 reference divider; 8,10,12-15 unused.
// - shutdown bit set powers everything down regardless of other bits.
// - global output enable zero forces all clock outputs off.
// - pump float bit set puts charge pump output in high impedance.
// - pump polarity 0 negative default, 1 positive.
// - feedback ratio 18-bit binary, 1 to 262143, zero invalid, defaults 760.
// - total feedback ratio is prescaler times feedback divider.
// - pump gain 0,1,2,3 gives 1x,4x,16x,32x current.
// - above 20 MHz detector rate host sets lock detect prescale by four.
`ifndef PCW_CONSTS_SVH
`define PCW_CONSTS_SVH

`define PCW_WORD_BITS      32
`define PCW_ADDR_A         4'hE
`define PCW_ADDR_B         4'hF
`define PCW_ADDR_LSB       0
`define PCW_ADDR_MSB       3

`define PCW_A_REF_LSB      8
`define PCW_A_REF_MSB      19
`define PCW_A_LDSEL_LSB    20
`define PCW_A_LDSEL_MSB    23
`define PCW_A_POL_BIT      24
`define PCW_A_FLOAT_BIT    25
`define PCW_A_SHUT_BIT     26
`define PCW_A_GOE_BIT      27

`define PCW_B_FB_LSB       8
`define PCW_B_FB_MSB       25
`define PCW_B_GAIN_LSB     30
`define PCW_B_GAIN_MSB     31

`define PCW_REF_RST        12'h00A
`define PCW_FB_RST         18'h002F8
`define PCW_LDSEL_RST      4'h0
`define PCW_GAIN_RST       2'h0
`define PCW_POL_RST        1'b0
`define PCW_FLOAT_RST      1'b0
`define PCW_SHUT_RST       1'b0
`define PCW_GOE_RST        1'b1

`define PCW_GAIN_X1        6'h01
`define PCW_GAIN_X4        6'h04
`define PCW_GAIN_X16       6'h10
`define PCW_GAIN_X32       6'h20

`endif

//--- src/pcw_pkg.sv
/*
 * Types for the configuration word block.
 * Assumes pcw_consts.svh is on the include path.
 */
`include "pcw_consts.svh"

package pcw_pkg;

    typedef enum logic [3:0] {
        PCW_LD_HIZ      = 4'h0,
        PCW_LD_HIGH     = 4'h1,
        PCW_LD_LOW      = 4'h2,
        PCW_LD_DLD_HI   = 4'h3,
        PCW_LD_DLD_LO   = 4'h4,
        PCW_LD_ALD_PP   = 4'h5,
        PCW_LD_ALD_NMOS = 4'h6,
        PCW_LD_ALD_PMOS = 4'h7,
        PCW_LD_FB_HALF  = 4'h9,
        PCW_LD_REF_OUT  = 4'hB
    } pcw_ld_sel_t;

endpackage : pcw_pkg

//--- src/pcw_shift_rx.sv
/*
 * Three-wire serial receiver on the link clock: shifts data msb first and
 * hands a full word across to the system clock on the latch-enable rise.
 * Assumes the link clock runs only while the host shifts; latch enable crosses
 * by a two-flop synchroniser and the word is sampled directly while stable.
 */
`timescale 1ns/1ps
`include "pcw_consts.svh"

module pcw_shift_rx (
    input  wire logic                     link_clk_in,
    input  wire logic                     sys_clk_in,
    input  wire logic                     sys_rst_in,
    input  wire logic                     ser_data_in,
    input  wire logic                     latch_en_in,
    output logic [`PCW_WORD_BITS-1:0]     word_out,
    output logic                          word_strobe_out
);

    ////////////////////////////////////////////////////////////////////////
    // link domain shift register
    logic [`PCW_WORD_BITS-1:0] shift;
    logic [`PCW_WORD_BITS-1:0] next_shift;

    always_comb begin
        next_shift = {shift[`PCW_WORD_BITS-2:0], ser_data_in};
    end

    always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            shift <= '0;
        end else begin
            shift <= next_shift;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system domain: latch enable synchronised, rise captures the word
    // shift is stable while latch enable is high since the link clock stops
    logic       le_s1;
    logic       le_s2;
    logic       le_s3;
    logic [`PCW_WORD_BITS-1:0] hold;
    logic [`PCW_WORD_BITS-1:0] next_hold;
    logic       strobe;
    logic       next_strobe;

    always_comb begin
        next_strobe = le_s2 & ~le_s3;
        next_hold   = hold;
        if (next_strobe) begin
            next_hold = shift;
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            le_s1  <= 1'b0;
            le_s2  <= 1'b0;
            le_s3  <= 1'b0;
            hold   <= '0;
            strobe <= 1'b0;
        end else begin
            le_s1  <= latch_en_in;
            le_s2  <= le_s1;
            le_s3  <= le_s2;
            hold   <= next_hold;
            strobe <= next_strobe;
        end
    end

    assign word_out        = hold;
    assign word_strobe_out = strobe;

endmodule : pcw_shift_rx

//--- sim/pcw_host_model.sv
/*
 * Host model for the three-wire configuration port: shifts words msb first
 * and pulses latch enable.
 * Assumes the testbench calls its tasks one at a time and drives no pins.
 */
`timescale 1ns/1ps

module pcw_host_model (
    output logic ser_clk_out,
    output logic ser_data_out,
    output logic latch_en_out
);

    initial begin
        ser_clk_out  = 1'b0;
        ser_data_out = 1'b1;
        latch_en_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // link clock runs only inside a frame; slow stretches its low phase
    task automatic shift_word(input logic [31:0] w, input int slow);
        for (int i = 31; i >= 0; i--) begin
            ser_data_out = w[i];
            #(15 + slow) ser_clk_out = 1'b1;
            #15 ser_clk_out = 1'b0;
        end
        // released line shows the inverse, not the last bit
        ser_data_out = ~w[0];
    endtask : shift_word

    // latch only after a whole word; held well over 4 system clocks
    task automatic latch_word();
        #30 latch_en_out = 1'b1;
        #240 latch_en_out = 1'b0;
        #60;
    endtask : latch_word

endmodule : pcw_host_model

//--- sim/pcw_config_regs_assertions.sv
/*
 * Output relations of the configuration word block.
 * Assumes binding at pcw_config_regs, one system clock domain.
 */
`timescale 1ns/1ps

module pcw_config_regs_checker (
    input wire logic        sys_clk_in,
    input wire logic        sys_rst_in,
    input wire logic        latch_en_in,
    input wire logic [11:0] ref_ratio_out,
    input wire logic [17:0] fb_ratio_out,
    input wire logic        ref_ratio_bad_out,
    input wire logic        fb_ratio_bad_out,
    input wire logic        full_shutdown_bit_out,
    input wire logic        clocks_off_out,
    input wire logic        pump_float_bit_out,
    input wire logic        pump_polarity_bit_out,
    input wire logic [5:0]  pump_gain_scale_out,
    input wire logic        lock_status_pin_oe_out,
    input wire logic        ld_sel_bad_out
);

    logic [3:0] since_latch;
    logic [3:0] next_since_latch;

    // raw latch level; the design syncs it, so allow a few cycles of slack
    always_comb begin
        next_since_latch = latch_en_in ? 4'h0 : since_latch + {3'h0, since_latch != 4'hF};
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) since_latch <= 4'hF;
        else since_latch <= next_since_latch;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    AST_OFF_SHUT: assert property (full_shutdown_bit_out |-> clocks_off_out)
        else $error("clock outputs on during shutdown");
    AST_FLOAT_SHUT: assert property (full_shutdown_bit_out |-> pump_float_bit_out)
        else $error("pump driving during shutdown");
    AST_SHUT_PIN: assert property (full_shutdown_bit_out |=> !lock_status_pin_oe_out)
        else $error("lock pin driven during shutdown");
    AST_SEL_BAD: assert property (ld_sel_bad_out |-> !lock_status_pin_oe_out)
        else $error("lock pin driven on unused select code");
    AST_REF_BAD: assert property (ref_ratio_bad_out == (ref_ratio_out == 12'h000))
        else $error("reference ratio flag wrong");
    AST_FB_BAD: assert property (fb_ratio_bad_out == (fb_ratio_out == 18'h00000))
        else $error("feedback ratio flag wrong");
    AST_GAIN: assert property (pump_gain_scale_out inside {6'h01, 6'h04, 6'h10, 6'h20})
        else $error("pump gain scale not a legal step");
    AST_HOLD: assert property (($changed(ref_ratio_out) || $changed(fb_ratio_out)
        || $changed(pump_polarity_bit_out)) |-> since_latch < 4'h8)
        else $error("field changed without a latch");

endmodule : pcw_config_regs_checker

bind pcw_config_regs pcw_config_regs_checker i_chk (.sys_clk_in, .sys_rst_in, .latch_en_in,
    .ref_ratio_out, .fb_ratio_out, .ref_ratio_bad_out, .fb_ratio_bad_out, .full_shutdown_bit_out,
    .clocks_off_out, .pump_float_bit_out, .pump_polarity_bit_out, .pump_gain_scale_out,
    .lock_status_pin_oe_out, .ld_sel_bad_out);

//--- sim/pcw_testbench.sv
/*
 * Self-checking bench for pcw_config_regs with the host model on its port.
 * Assumes the checker is bound by its own file.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end

module testbench;

    logic        sys_clk_in = 1'b0, sys_rst_in = 1'b1, ser_clk_in, ser_data_in, latch_en_in;
    logic        dig_lock_in = 1'b0, ana_lock_in = 1'b0, ld_prescale_in = 1'b0;
    logic        fb_div_pulse_in = 1'b0, ref_div_pulse_in = 1'b0;
    logic [11:0] ref_ratio_out;
    logic [17:0] fb_ratio_out;
    logic [5:0]  pump_gain_scale_out;
    logic        ref_ratio_bad_out, fb_ratio_bad_out, full_shutdown_bit_out, clocks_off_out;
    logic        pump_float_bit_out, pump_polarity_bit_out, lock_detect_prescale_out;
    logic        lock_status_pin_out, lock_status_pin_oe_out, ld_sel_bad_out;
    int          err_total = 0, checks = 0, cyc = 0;

    pcw_config_regs i_dut (.sys_clk_in, .sys_rst_in, .ser_clk_in, .ser_data_in, .latch_en_in,
        .dig_lock_in, .ana_lock_in, .fb_div_pulse_in, .ref_div_pulse_in, .ld_prescale_in,
        .ref_ratio_out, .fb_ratio_out, .ref_ratio_bad_out, .fb_ratio_bad_out,
        .full_shutdown_bit_out, .clocks_off_out, .pump_float_bit_out, .pump_polarity_bit_out,
        .pump_gain_scale_out, .lock_detect_prescale_out, .lock_status_pin_out,
        .lock_status_pin_oe_out, .ld_sel_bad_out);
    pcw_host_model i_host (.ser_clk_out(ser_clk_in), .ser_data_out(ser_data_in),
        .latch_en_out(latch_en_in));

    always #12.5 sys_clk_in = ~sys_clk_in;

    // divider pulses and timeout; a hang counts as a mismatch
    always @(posedge sys_clk_in) begin
        fb_div_pulse_in <= 1'($urandom);
        ref_div_pulse_in <= 1'($urandom);
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] word_a(logic [11:0] r, logic [3:0] s, logic p, f, d, g);
        return {4'h0, g, d, f, p, s, r, 4'h0, 4'hE};
    endfunction : word_a

    function automatic logic pin_exp(logic [3:0] s, logic dl, logic al);
        return (s == 4'h1) | (s == 4'h3 & dl) | (s == 4'h4 & !dl) | (s == 4'h5 & al);
    endfunction : pin_exp

    task automatic load(input logic [31:0] w, input int slow);
        @(posedge sys_clk_in);
        dig_lock_in <= 1'($urandom);
        ana_lock_in <= 1'($urandom);
        i_host.shift_word(w, slow);
        i_host.latch_word();
        repeat (4) @(posedge sys_clk_in);
        #1;
    endtask : load

    task automatic check_a(logic [11:0] r, logic [3:0] s, logic p, f, d, g);
        logic bad;
        bad = (s == 4'h8) || (s == 4'hA) || (s >= 4'hC);
        `CHK("ref", r, ref_ratio_out)
        `CHK("ref_bad", r == 12'h000, ref_ratio_bad_out)
        `CHK("shutdown", d, full_shutdown_bit_out)
        `CHK("clocks_off", !g || d, clocks_off_out)
        `CHK("float", f || d, pump_float_bit_out)
        `CHK("polarity", p, pump_polarity_bit_out)
        `CHK("sel_bad", bad, ld_sel_bad_out)
        if (d || bad || s == 4'h0) `CHK("pin_oe", 1'b0, lock_status_pin_oe_out)
        else if (s < 4'h6 || s > 4'h8) begin
            `CHK("pin_oe", 1'b1, lock_status_pin_oe_out)
            if (s < 4'h6) `CHK("pin", pin_exp(s, dig_lock_in, ana_lock_in), lock_status_pin_out)
        end
        else `CHK("pin_oe", (s == 4'h6) ^ ana_lock_in, lock_status_pin_oe_out)
    endtask : check_a

    task automatic results();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [11:0] r;
        logic [17:0] fb;
        logic [31:0] w;
        logic        p, f, d, g;
        void'($urandom(32'hAB00));
        repeat (10) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        #1;
        check_a(12'h00A, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1);
        `CHK("fb", 18'h002F8, fb_ratio_out)
        `CHK("gain", 6'h01, pump_gain_scale_out)
        for (int i = 0; i < 32; i++) begin
            r = (i == 0) ? 12'h000 : (i == 1) ? 12'h001 : (i == 2) ? 12'hFFF : 12'($urandom_range(1, 4095));
            {p, f, g} = 3'($urandom);
            d = (i % 7 == 6);
            load(word_a(r, i[3:0], p, f, d, g), (i % 3) * 20);
            check_a(r, i[3:0], p, f, d, g);
        end
        for (int i = 0; i < 12; i++) begin
            fb = (i == 0) ? 18'h00000 : (i == 1) ? 18'h3FFFF : 18'($urandom_range(1, 262143));
            load({i[1:0], 4'h0, fb, 4'h0, 4'hF}, 0);
            `CHK("fb", fb, fb_ratio_out)
            `CHK("fb_bad", fb == 18'h00000, fb_ratio_bad_out)
            `CHK("gain", (i[1:0] == 2'h3) ? 6'h20 : 6'h01 << (2 * i[1:0]), pump_gain_scale_out)
        end
        // a word shifted but not latched must not take effect
        load(word_a(12'h0FF, 4'h1, 1'b0, 1'b0, 1'b0, 1'b1), 0);
        i_host.shift_word(word_a(12'h123, 4'h2, 1'b1, 1'b0, 1'b0, 1'b1), 10);
        repeat (8) @(posedge sys_clk_in);
        #1;
        `CHK("ref", 12'h0FF, ref_ratio_out)
        i_host.latch_word();
        repeat (4) @(posedge sys_clk_in);
        #1;
        check_a(12'h123, 4'h2, 1'b1, 1'b0, 1'b0, 1'b1);
        w = word_a(12'h456, 4'h1, 1'b0, 1'b0, 1'b0, 1'b1);
        w[3:0] = 4'h5;
        load(w, 0);
        `CHK("ref", 12'h123, ref_ratio_out)
        @(posedge sys_clk_in);
        ld_prescale_in <= 1'b1;
        repeat (6) @(posedge sys_clk_in);
        #1;
        `CHK("prescale", 1'b1, lock_detect_prescale_out)
        sys_rst_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        ld_prescale_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        #1;
        check_a(12'h00A, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1);
        `CHK("fb", 18'h002F8, fb_ratio_out)
        results();
    end

endmodule : testbench
